// file: rtl/cod_decoder.sv
`timescale 1ns/10ps
// Contract
// - f8 clears carry, f5 inverts, f9 sets; two cycles each.
// - fc clears direction, fd sets; two cycles each.
// - fa clears interrupt enable, fb sets; two cycles each.
// - f0 is lock prefix for next instruction, costing two cycles.
// - mode 11 makes the r/m field select a register.
// - mode 00 means zero displacement, no bytes, except direct address.
// - mode 01 takes one byte sign extended to 16 bits.
// - mode 10 takes high byte above low byte.
// - r/m 000-011 add base register or base pointer plus an index.
// - r/m 100-111 add source, destination, base pointer, base register.
// - mode 00 r/m 110 uses the displacement as address directly.
// - displacement bytes follow the second byte, before immediate data.
// - effective address computation takes four cycles in all modes.
// - override field picks extra, code, stack or data segment.
// - reg field picks word registers or low then high bytes.
// - base pointer addressing defaults to the stack segment.
// - string destinations via destination index always use extra segment.
module cod_decoder
  import cod_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic first_byte,
  input wire logic [15:0] base_register,
  input wire logic [15:0] base_pointer,
  input wire logic [15:0] source_index,
  input wire logic [15:0] destination_index,
  input wire logic string_dest,
  input wire logic word_width,
  output logic byte_ready,
  output logic carry_flag,
  output logic direction_flag,
  output logic int_enable_flag,
  output logic bus_lock,
  output logic prefix_done,
  output logic op_done,
  output logic ea_valid,
  output logic [15:0] effective_address,
  output logic [1:0] segment_sel,
  output logic reg_operand,
  output logic [2:0] reg_index,
  output logic reg_high_byte,
  output logic [2:0] rm_reg_index,
  output logic rm_high_byte
);
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_MODRM,
    ST_DLO,
    ST_DHI,
    ST_CTRL,
    ST_EA
  } cod_state_type;
  typedef struct packed {
    cod_state_type st;
    logic [2:0] cnt;
    logic carry;
    logic dir;
    logic ie;
    logic lock_pend;
    logic lock_act;
    logic ovr_pend;
    logic [1:0] ovr_seg;
    logic ovr_act;
    logic [1:0] ovr_act_seg;
    logic [7:0] pend_op;
    logic [1:0] mode;
    logic [2:0] regf;
    logic [2:0] rm;
    logic [7:0] dlo;
    logic [7:0] dhi;
    logic [1:0] need;
    logic pfx_done;
    logic done;
    logic eav;
    logic [15:0] ea;
    logic [1:0] seg;
    logic regop;
  } cod_regs_type;
  cod_regs_type r;
  cod_regs_type next_r;
  logic [15:0] ea_comb;
  logic ea_bp;
  logic [1:0] ea_bytes;
  logic take;
  cod_ea_unit u_ea (
    .mode(r.mode),
    .rm(r.rm),
    .disp_lo(r.dlo),
    .disp_hi(r.dhi),
    .base_register(base_register),
    .base_pointer(base_pointer),
    .source_index(source_index),
    .destination_index(destination_index),
    .ea(ea_comb),
    .uses_bp(ea_bp),
    .disp_bytes(ea_bytes)
  );
  assign take = byte_valid && byte_ready;
  always_comb begin
    byte_ready = (r.st == ST_OPCODE) || (r.st == ST_MODRM) || (r.st == ST_DLO) || (r.st == ST_DHI);
  end
  always_comb begin
    next_r = r;
    next_r.pfx_done = 1'b0;
    next_r.done = 1'b0;
    next_r.eav = 1'b0;
    unique case (r.st)
      ST_OPCODE: begin
        if (take && first_byte) begin
          next_r.pend_op = byte_data;
          if (byte_data == OP_LOCK) begin
            next_r.lock_pend = 1'b1;
            next_r.st = ST_CTRL;
            next_r.cnt = CTRL_CYCLES;
          end else if ((byte_data & SEG_PFX_MASK) == SEG_PFX_VAL) begin
            next_r.ovr_pend = 1'b1;
            next_r.ovr_seg = byte_data[4:3];
            next_r.pfx_done = 1'b1;
          end else begin
            next_r.lock_act = r.lock_pend;
            next_r.lock_pend = 1'b0;
            next_r.ovr_act = r.ovr_pend;
            next_r.ovr_act_seg = r.ovr_seg;
            next_r.ovr_pend = 1'b0;
            if (byte_data == OP_CARRY_CLEAR || byte_data == OP_CARRY_INVERT || byte_data == OP_CARRY_SET ||
                byte_data == OP_DIR_CLEAR || byte_data == OP_DIR_SET || byte_data == OP_INT_CLEAR ||
                byte_data == OP_INT_SET) begin
              next_r.st = ST_CTRL;
              next_r.cnt = CTRL_CYCLES;
            end else begin
              next_r.st = ST_MODRM;
            end
          end
        end
      end
      ST_MODRM: begin
        if (take) begin
          next_r.mode = byte_data[7:6];
          next_r.regf = byte_data[5:3];
          next_r.rm = byte_data[2:0];
          if (byte_data[7:6] == MOD_DISP8 || byte_data[7:6] == MOD_DISP16 ||
              (byte_data[7:6] == MOD_NODISP && byte_data[2:0] == RM_DIRECT)) begin
            next_r.st = ST_DLO;
          end else begin
            next_r.st = ST_EA;
            next_r.cnt = EA_CYCLES;
          end
          next_r.dlo = 8'h00;
          next_r.dhi = 8'h00;
        end
      end
      ST_DLO: begin
        if (take) begin
          next_r.dlo = byte_data;
          // no high byte for mode 01
          if (r.mode == MOD_DISP8) begin
            next_r.st = ST_EA;
            next_r.cnt = EA_CYCLES;
          end else begin
            next_r.st = ST_DHI;
          end
        end
      end
      ST_DHI: begin
        if (take) begin
          next_r.dhi = byte_data;
          next_r.st = ST_EA;
          next_r.cnt = EA_CYCLES;
        end
      end
      ST_CTRL: begin
        next_r.cnt = 3'(r.cnt - 3'h1);
        if (r.cnt == 3'h1) begin
          next_r.st = ST_OPCODE;
          if (r.pend_op == OP_LOCK) begin
            next_r.pfx_done = 1'b1;
          end else begin
            next_r.done = 1'b1;
            next_r.lock_act = 1'b0;
            next_r.ovr_act = 1'b0;
          end
          unique case (r.pend_op)
            OP_CARRY_CLEAR: next_r.carry = 1'b0;
            OP_CARRY_INVERT: next_r.carry = ~r.carry;
            OP_CARRY_SET: next_r.carry = 1'b1;
            OP_DIR_CLEAR: next_r.dir = 1'b0;
            OP_DIR_SET: next_r.dir = 1'b1;
            OP_INT_CLEAR: next_r.ie = 1'b0;
            OP_INT_SET: next_r.ie = 1'b1;
            default: next_r.carry = r.carry;
          endcase
        end
      end
      ST_EA: begin
        next_r.cnt = 3'(r.cnt - 3'h1);
        if (r.cnt == 3'h1) begin
          next_r.st = ST_OPCODE;
          next_r.eav = 1'b1;
          next_r.done = 1'b1;
          next_r.lock_act = 1'b0;
          next_r.ovr_act = 1'b0;
          next_r.regop = (r.mode == MOD_REG);
          next_r.ea = (r.mode == MOD_REG) ? 16'h0000 : ea_comb;
          next_r.seg = SEG_DATA;
          if (ea_bp) begin
            next_r.seg = SEG_STACK;
          end
          if (r.ovr_act) begin
            next_r.seg = r.ovr_act_seg;
          end
          if (string_dest) begin
            next_r.seg = SEG_EXTRA;
          end
        end
      end
      default: next_r.st = ST_OPCODE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= ST_OPCODE;
      r.cnt <= RST_CNT;
    end else begin
      r <= next_r;
    end
  end
  assign carry_flag = r.carry;
  assign direction_flag = r.dir;
  assign int_enable_flag = r.ie;
  assign bus_lock = r.lock_act;
  assign prefix_done = r.pfx_done;
  assign op_done = r.done;
  assign ea_valid = r.eav;
  assign effective_address = r.ea;
  assign segment_sel = r.seg;
  assign reg_operand = r.regop;
  assign reg_index = word_width ? r.regf : {1'b0, r.regf[1:0]};
  assign reg_high_byte = !word_width && r.regf[2];
  assign rm_reg_index = word_width ? r.rm : {1'b0, r.rm[1:0]};
  assign rm_high_byte = !word_width && r.rm[2];

  sequence s_ctrl_start;
    take && first_byte && (byte_data == OP_CARRY_SET);
  endsequence
  sequence s_locked_op;
    (r.st == ST_OPCODE) && take && first_byte && r.lock_pend && (byte_data != OP_LOCK) &&
      ((byte_data & SEG_PFX_MASK) != SEG_PFX_VAL);
  endsequence
  a_carry_set_time: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_ctrl_start |-> ##3 (carry_flag && op_done)) else $error("carry set timing wrong");
  a_dir_set_time: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take && first_byte && byte_data == OP_DIR_SET) |-> ##3 direction_flag) else $error("direction not set");
  a_int_clear_time: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take && first_byte && byte_data == OP_INT_CLEAR) |-> ##3 !int_enable_flag) else $error("ie not cleared");
  a_lock_prefix_cost: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (take && first_byte && byte_data == OP_LOCK) |=> !byte_ready [*2] ##1 prefix_done) else $error("lock cost wrong");
  a_lock_next_op: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_locked_op |=> bus_lock) else $error("lock not applied");
  a_lock_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
    op_done |-> !bus_lock) else $error("lock held too long");
  a_ea_four_cycles: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (r.st == ST_EA && $past(r.st) != ST_EA) |-> (r.st == ST_EA) [*4] ##1 ea_valid) else $error("ea timing wrong");
  a_string_extra: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (r.st == ST_EA && r.cnt == 3'h1 && string_dest) |=> (segment_sel == SEG_EXTRA)) else $error("string seg wrong");
  a_override_seg: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (r.st == ST_EA && r.cnt == 3'h1 && r.ovr_act && !string_dest) |=> (segment_sel == $past(r.ovr_act_seg)))
    else $error("override segment lost");
  a_reg_mode_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ea_valid |-> (reg_operand == ($past(r.mode) == MOD_REG))) else $error("reg operand wrong");
  a_disp8_one_byte: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (r.st == ST_DLO && take && r.mode == MOD_DISP8) |=> (r.st == ST_EA)) else $error("disp8 fetched high");
  a_disp_fetch_plan: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (r.st == ST_DHI) |-> (ea_bytes == 2'h2)) else $error("high byte not expected");
endmodule

// file: rtl/cod_pkg.sv
package cod_pkg;
  localparam logic [7:0] OP_CARRY_CLEAR = 8'hf8;
  localparam logic [7:0] OP_CARRY_INVERT = 8'hf5;
  localparam logic [7:0] OP_CARRY_SET = 8'hf9;
  localparam logic [7:0] OP_DIR_CLEAR = 8'hfc;
  localparam logic [7:0] OP_DIR_SET = 8'hfd;
  localparam logic [7:0] OP_INT_CLEAR = 8'hfa;
  localparam logic [7:0] OP_INT_SET = 8'hfb;
  localparam logic [7:0] OP_LOCK = 8'hf0;
  localparam logic [7:0] SEG_PFX_MASK = 8'he7;
  localparam logic [7:0] SEG_PFX_VAL = 8'h26;
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;
  localparam logic [2:0] CTRL_CYCLES = 3'h2;
  localparam logic [2:0] EA_CYCLES = 3'h4;
  localparam logic [2:0] RST_CNT = 3'h0;
endpackage

// file: rtl/cod_ea_unit.sv
`timescale 1ns/10ps
module cod_ea_unit
  import cod_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic [2:0] rm,
  input wire logic [7:0] disp_lo,
  input wire logic [7:0] disp_hi,
  input wire logic [15:0] base_register,
  input wire logic [15:0] base_pointer,
  input wire logic [15:0] source_index,
  input wire logic [15:0] destination_index,
  output logic [15:0] ea,
  output logic uses_bp,
  output logic [1:0] disp_bytes
);
  logic [15:0] disp;
  logic direct;
  always_comb begin
    direct = (mode == MOD_NODISP) && (rm == RM_DIRECT);
    disp = 16'h0000;
    disp_bytes = 2'h0;
    if (mode == MOD_DISP8) begin
      disp = {{8{disp_lo[7]}}, disp_lo};
      disp_bytes = 2'h1;
    end
    if (mode == MOD_DISP16 || direct) begin
      disp = {disp_hi, disp_lo};
      disp_bytes = 2'h2;
    end
    uses_bp = 1'b0;
    ea = disp;
    unique case (rm)
      3'h0: ea = 16'(base_register + source_index + disp);
      3'h1: ea = 16'(base_register + destination_index + disp);
      3'h2: begin
        ea = 16'(base_pointer + source_index + disp);
        uses_bp = 1'b1;
      end
      3'h3: begin
        ea = 16'(base_pointer + destination_index + disp);
        uses_bp = 1'b1;
      end
      3'h4: ea = 16'(source_index + disp);
      3'h5: ea = 16'(destination_index + disp);
      3'h6: begin
        ea = 16'(base_pointer + disp);
        uses_bp = 1'b1;
      end
      3'h7: ea = 16'(base_register + disp);
    endcase
    if (direct) begin
      ea = disp;
      uses_bp = 1'b0;
    end
  end
endmodule

// file: testbench/cod_fetch_model.sv
`timescale 1ns/10ps
module cod_fetch_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [2:0] count,
  input wire logic [39:0] bytes,
  input wire logic [4:0] firsts,
  input wire logic [1:0] stall,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic first_byte,
  output logic done
);
  logic busy;
  logic [2:0] idx;
  logic [1:0] wait_cnt;
  logic [7:0] last;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      idx <= 3'h0;
      wait_cnt <= 2'h0;
      last <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        idx <= 3'h0;
        wait_cnt <= stall;
      end else if (busy && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (byte_valid && byte_ready) begin
        last <= byte_data;
        idx <= idx + 3'h1;
        wait_cnt <= stall;
        if (idx == count - 3'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
  assign byte_valid = busy && wait_cnt == 2'h0;
  // released bus shows the inverse of the last byte
  assign byte_data = byte_valid ? bytes[{idx, 3'h0} +: 8] : ~last;
  assign first_byte = byte_valid ? firsts[idx] : 1'b0;
endmodule

// file: testbench/ctrl_op_and_operand_addr_decode_bench.sv
`timescale 1ns/10ps
module ctrl_op_and_operand_addr_decode_bench;
  logic ref_clk = 0, arst_n = 0, start = 0, string_dest = 0, word_width = 0;
  logic [2:0] count = 0;
  logic [39:0] bytes = 0;
  logic [4:0] firsts = 0;
  logic [1:0] stall = 0;
  logic [15:0] vbase = 0, vptr = 0, vsrc = 0, vdst = 0;
  logic byte_valid, first_byte, byte_ready, done, carry_flag, direction_flag, int_enable_flag;
  logic bus_lock, prefix_done, op_done, ea_valid, reg_operand, reg_high_byte, rm_high_byte;
  logic lock_seen = 0;
  logic [7:0] byte_data;
  logic [15:0] effective_address;
  logic [1:0] segment_sel;
  logic [2:0] reg_index, rm_reg_index;
  logic [31:0] seed = 32'h2e81;
  int err_count = 0, checks_done = 0;
  always #2 ref_clk = ~ref_clk;
  cod_fetch_model u_fetch (.ref_clk, .arst_n, .start, .count, .bytes, .firsts, .stall, .byte_ready,
    .byte_valid, .byte_data, .first_byte, .done);
  cod_decoder u_dut (.ref_clk, .arst_n, .byte_valid, .byte_data, .first_byte, .base_register(vbase),
    .base_pointer(vptr), .source_index(vsrc), .destination_index(vdst), .string_dest, .word_width,
    .byte_ready, .carry_flag, .direction_flag, .int_enable_flag, .bus_lock, .prefix_done, .op_done,
    .ea_valid, .effective_address, .segment_sel, .reg_operand, .reg_index, .reg_high_byte,
    .rm_reg_index, .rm_high_byte);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_ea(input logic [1:0] md, input logic [2:0] rm, input logic [15:0] d);
    logic [15:0] b;
    case (rm)
      3'h0: b = vbase + vsrc;
      3'h1: b = vbase + vdst;
      3'h2: b = vptr + vsrc;
      3'h3: b = vptr + vdst;
      3'h4: b = vsrc;
      3'h5: b = vdst;
      3'h6: b = md == 2'h0 ? 16'h0 : vptr;
      default: b = vbase;
    endcase
    return md == 2'h3 ? 16'h0 : b + d;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_lat(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input logic [2:0] n, input logic [39:0] b, input int which, output int lat);
    int k;
    logic p;
    k = 0;
    lat = 0;
    count = n;
    bytes = b;
    firsts = 5'h1;
    stall = 2'(rnd());
    start = 1;
    @(posedge ref_clk);
    #1 start = 0;
    while (done !== 1'b1 && k < 60) begin
      @(posedge ref_clk);
      #1 k++;
    end
    if (k >= 60) err_count++;
    lat = 1;
    p = which == 0 ? op_done : which == 1 ? prefix_done : ea_valid;
    lock_seen = bus_lock;
    while (p !== 1'b1 && lat < 20) begin
      @(posedge ref_clk);
      #1 lat++;
      p = which == 0 ? op_done : which == 1 ? prefix_done : ea_valid;
      lock_seen |= bus_lock;
    end
  endtask
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  initial begin
    int lat;
    logic [7:0] op, lo, hi;
    logic [1:0] md, ss;
    logic [2:0] rm, rg, fl, nb;
    logic pf, ubp;
    logic [15:0] d;
    logic [7:0] ops [7];
    ops = '{8'hf8, 8'hf5, 8'hf9, 8'hfc, 8'hfd, 8'hfa, 8'hfb};
    repeat (10) @(posedge ref_clk);
    #1 arst_n = 1;
    send(3'h1, 40'hf0, 1, lat);
    chk_lat(lat, 3);
    chk(bus_lock, 16'h0);
    send(3'h1, 40'hf9, 0, lat);
    chk(lock_seen, 16'h1);
    chk(bus_lock, 16'h0);
    fl = 3'h1;
    for (int i = 0; i < 21; i++) begin
      op = ops[i < 7 ? i : rnd() % 7];
      case (op)
        8'hf8: fl[0] = 1'b0;
        8'hf5: fl[0] = ~fl[0];
        8'hf9: fl[0] = 1'b1;
        8'hfc: fl[1] = 1'b0;
        8'hfd: fl[1] = 1'b1;
        8'hfa: fl[2] = 1'b0;
        default: fl[2] = 1'b1;
      endcase
      send(3'h1, {32'h0, op}, 0, lat);
      chk_lat(lat, 3);
      chk({int_enable_flag, direction_flag, carry_flag}, fl);
    end
    for (int i = 0; i < 40; i++) begin
      {md, rm, rg, ss, pf, string_dest, word_width} = 13'(rnd());
      {lo, hi} = 16'(rnd());
      {vbase, vptr} = rnd();
      {vsrc, vdst} = rnd();
      if (i < 4) begin
        md = 2'(i);
        rm = 3'h6;
        lo = 8'h9c;
      end
      nb = md == 2'h1 ? 3'h1 : (md == 2'h2 || (md == 2'h0 && rm == 3'h6)) ? 3'h2 : 3'h0;
      d = md == 2'h1 ? {{8{lo[7]}}, lo} : nb == 3'h2 ? {hi, lo} : 16'h0;
      ubp = rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && md != 2'h0);
      if (pf) begin
        send(3'h1, {32'h0, 3'h1, ss, 3'h6}, 1, lat);
        chk_lat(lat, 1);
      end
      send(nb + 3'h2, {8'h0, hi, lo, md, rg, rm, 8'h8b}, 2, lat);
      chk_lat(lat, 5);
      chk(effective_address, exp_ea(md, rm, d));
      chk(reg_operand, {15'h0, md == 2'h3});
      chk({reg_high_byte, reg_index}, {!word_width && rg[2], word_width ? rg : {1'b0, rg[1:0]}});
      if (md == 2'h3) chk({rm_high_byte, rm_reg_index}, {!word_width && rm[2], word_width ? rm : {1'b0, rm[1:0]}});
      else chk(segment_sel, string_dest ? 2'h0 : pf ? ss : ubp ? 2'h2 : 2'h3);
    end
    end_sim();
  end
endmodule
